// *** dv/fecs_top_sva.sv ***
// assertion checker for the fan config and smoothing block
`timescale 1ns/1ps
module fecs_top_chk (
    input wire logic        CORE_CLK_IN,
    input wire logic        RST_B_IN,
    input wire logic        CLK_EN_IN,
    input wire logic [9:0]  AVS_ADDRESS_IN,
    input wire logic        AVS_READ_IN,
    input wire logic        AVS_WRITE_IN,
    input wire logic [31:0] AVS_READDATA_OUT,
    input wire logic        AVS_WAITREQUEST_OUT,
    input wire logic        FREQ_22K5_IN,
    input wire logic        SPINUP_IN,
    input wire logic [7:0]  SPINUP_DUTY_IN,
    input wire logic        CRIT_TEMP_EVENT_IN,
    input wire logic [7:0]  CRIT_DUTY_IN,
    input wire logic        FILTER_ON_IN,
    input wire logic [7:0]  REMOTE_LSB_RAW_IN,
    input wire logic [7:0]  REMOTE_LSB_OUT,
    input wire logic [7:0]  DUTY_OUT,
    input wire logic        FINE_DUTY_SELECT_OUT,
    input wire logic        PWM_PROGRAM_ENABLE_OUT,
    input wire logic        RAMP_ACTIVE_OUT
);
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_taken;
        (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT && CLK_EN_IN;
    endsequence
    sequence s_answer;
        !AVS_WAITREQUEST_OUT && CLK_EN_IN;
    endsequence
    a_bus_answer: assert property (s_taken |=> !AVS_WAITREQUEST_OUT)
        else $error("request not answered next cycle");
    a_wait_pulse: assert property (s_answer |=> AVS_WAITREQUEST_OUT)
        else $error("answer lasted more than one cycle");
    a_rsvd_zero: assert property (
        !AVS_WAITREQUEST_OUT && AVS_READ_IN && AVS_ADDRESS_IN[9:2] == 8'h45
        |-> !AVS_READDATA_OUT[7]) else $error("top config bit read as one");
    a_lsb_pass: assert property (
        $past(CLK_EN_IN && RST_B_IN)
        |-> (REMOTE_LSB_OUT & 8'hE7) == ($past(REMOTE_LSB_RAW_IN) & 8'hE7))
        else $error("remote low byte not passed");
    a_lsb_mask: assert property (
        $past(CLK_EN_IN && RST_B_IN && !FILTER_ON_IN) |-> REMOTE_LSB_OUT[4:3] == 2'h0)
        else $error("filter bits shown with filter off");
    // both overrides land one cycle later, unsmoothed, quantized by the fine select
    a_crit_bypass: assert property (
        $past(CRIT_TEMP_EVENT_IN && CLK_EN_IN && RST_B_IN)
        |-> DUTY_OUT == ($past(CRIT_DUTY_IN) & ($past(FREQ_22K5_IN && FINE_DUTY_SELECT_OUT)
        ? 8'hFF : 8'hF0))) else $error("critical duty not applied");
    a_spin_bypass: assert property (
        $past(SPINUP_IN && !CRIT_TEMP_EVENT_IN && CLK_EN_IN && RST_B_IN)
        |-> DUTY_OUT == ($past(SPINUP_DUTY_IN) & ($past(FREQ_22K5_IN && FINE_DUTY_SELECT_OUT)
        ? 8'hFF : 8'hF0))) else $error("spin-up duty not applied");
    a_freq_noramp: assert property (
        $past(!FREQ_22K5_IN && !RAMP_ACTIVE_OUT && CLK_EN_IN && RST_B_IN) |-> !RAMP_ACTIVE_OUT)
        else $error("ramp started off frequency");
    a_ramp_step: assert property (
        $past(RAMP_ACTIVE_OUT && !CRIT_TEMP_EVENT_IN && !SPINUP_IN && !PWM_PROGRAM_ENABLE_OUT
        && FREQ_22K5_IN && FINE_DUTY_SELECT_OUT && RST_B_IN) && $changed(DUTY_OUT)
        |-> DUTY_OUT - $past(DUTY_OUT) == 8'h01 || $past(DUTY_OUT) - DUTY_OUT == 8'h01)
        else $error("ramp moved more than one step");
endmodule // fecs_top_chk

bind fecs_top fecs_top_chk u_chk (.*);

// *** dv/testbench.sv ***
// self-checking bench for the fan config and smoothing block
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    logic        clk, rst_b, rd, wr, freq, spin, crit, filt;
    logic [9:0]  addr;
    logic [31:0] wdata, rdata_o, x;
    logic [7:0]  spin_d, crit_d, lut, raw, lsb_o, duty_o;
    logic        cen;
    logic [3:0]  be;
    logic        wait_o, fine_o, lut_resolution_ext_o, usf_o, prog_o, ramp_o;
    int          error_cnt, check_count;
    // short ramp counts keep the run brief: 4, 8, 12, 16 cycles per step
    fecs_top #(.RAMP0_CYCLES(4), .RAMP1_CYCLES(8), .RAMP2_CYCLES(12), .RAMP3_CYCLES(16)) uut (
        .CORE_CLK_IN(clk), .RST_B_IN(rst_b), .CLK_EN_IN(cen),
        .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
        .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be),
        .AVS_READDATA_OUT(rdata_o), .AVS_WAITREQUEST_OUT(wait_o),
        .FREQ_22K5_IN(freq), .SPINUP_IN(spin), .SPINUP_DUTY_IN(spin_d),
        .CRIT_TEMP_EVENT_IN(crit), .CRIT_DUTY_IN(crit_d), .LUT_DUTY_IN(lut),
        .FILTER_ON_IN(filt), .REMOTE_LSB_RAW_IN(raw), .REMOTE_LSB_OUT(lsb_o),
        .DUTY_OUT(duty_o), .FINE_DUTY_SELECT_OUT(fine_o), .LUT_RESOLUTION_EXT_OUT(lut_resolution_ext_o),
        .SETPOINT_UNSIGNED_FORMAT_OUT(usf_o), .PWM_PROGRAM_ENABLE_OUT(prog_o),
        .RAMP_ACTIVE_OUT(ramp_o));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task finish_test;
        $display("checks=%0d mismatches=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        addr <= {idx, 2'b00};
        wdata <= {24'h0, d};
        wr <= w;
        rd <= !w;
        do begin @(posedge clk); n++; end while (wait_o !== 1'b0 && n < 50);
        if (n >= 50) begin error_cnt++; finish_test(); end
        x = rdata_o;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task wrr(input logic [7:0] idx, input logic [7:0] d); bus(1'b1, idx, d); endtask
    task rdc(input logic [7:0] idx, input logic [7:0] e); bus(1'b0, idx, 8'h00); `CHK(x, {24'h0, e})
    endtask
    task cyc(input int n); repeat (n) @(posedge clk); endtask
    // counts edges until the duty reaches the new table value
    task automatic ramp(input logic [7:0] tgt, input int e);
        int n;
        n = 0;
        lut <= tgt;
        do begin @(posedge clk); n++; end while (duty_o !== tgt && n < 300);
        `CHK(n, e)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0; rd = 1'b0; wr = 1'b0; addr = 10'h000; wdata = 32'h0; freq = 1'b1;
        spin = 1'b0; crit = 1'b0; filt = 1'b0; spin_d = 8'h00; crit_d = 8'h00;
        lut = 8'h00; raw = 8'h00; error_cnt = 0; check_count = 0;
        cen = 1'b1;
        be = 4'hF;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        rdc(8'h45, 8'h00);
        rdc(8'h4A, 8'h20);
        rdc(8'h4C, 8'h00);
        `CHK(prog_o, 1'b1)
        wrr(8'h40, 8'hFF);
        rdc(8'h40, 8'h00);
        // a write with the low byte lane off must not land
        be <= 4'hE;
        wrr(8'h4C, 8'h77);
        be <= 4'hF;
        rdc(8'h4C, 8'h00);
        $display("test reset done");
        wrr(8'h45, 8'hF9);
        rdc(8'h45, 8'h79);
        cyc(2);
        `CHK(fine_o, 1'b1)
        `CHK(lut_resolution_ext_o, 1'b1)
        `CHK(usf_o, 1'b1)
        wrr(8'h4C, 8'h35);
        cyc(2);
        `CHK(duty_o, 8'h35)
        freq <= 1'b0;
        cyc(2);
        `CHK(duty_o, 8'h30)
        freq <= 1'b1;
        raw <= 8'hFF;
        filt <= 1'b1;
        cyc(2);
        `CHK(lsb_o, 8'hFF)
        filt <= 1'b0;
        cyc(2);
        `CHK(lsb_o, 8'hE7)
        filt <= 1'b1;
        lut <= 8'h35;
        $display("test config done");
        wrr(8'h4A, 8'h00);
        wrr(8'h45, 8'h1E);
        rdc(8'h45, 8'h19);
        cyc(2);
        `CHK(lsb_o, 8'hE7)
        `CHK(prog_o, 1'b0)
        `CHK(lut_resolution_ext_o, 1'b0)
        wrr(8'h4C, 8'h80);
        for (int r = 0; r < 4; r++) begin
            wrr(8'h4A, 8'h20);
            cyc(2);
            `CHK(duty_o, 8'h35)
            wrr(8'h45, {5'b00111, r[1:0], 1'b1});
            wrr(8'h4A, 8'h00);
            ramp(8'h37, 8 * r + 10);
            `CHK(ramp_o, 1'b1)
        end
        $display("test ramp done");
        wrr(8'h4A, 8'h20);
        wrr(8'h45, 8'h38);
        wrr(8'h4A, 8'h00);
        ramp(8'h50, 2);
        `CHK(ramp_o, 1'b0)
        wrr(8'h4A, 8'h20);
        wrr(8'h4C, 8'h50);
        wrr(8'h45, 8'h39);
        wrr(8'h4A, 8'h00);
        freq <= 1'b0;
        lut <= 8'h70;
        cyc(2);
        `CHK(duty_o, 8'h70)
        `CHK(ramp_o, 1'b0)
        freq <= 1'b1;
        crit <= 1'b1;
        crit_d <= 8'hA5;
        cyc(2);
        `CHK(duty_o, 8'hA5)
        crit <= 1'b0;
        spin <= 1'b1;
        spin_d <= 8'h11;
        cyc(2);
        `CHK(duty_o, 8'h11)
        // a low clock enable must hold the duty even against a critical override
        cen <= 1'b0;
        crit <= 1'b1;
        crit_d <= 8'h5A;
        cyc(3);
        `CHK(duty_o, 8'h11)
        cen <= 1'b1;
        cyc(2);
        `CHK(duty_o, 8'h5A)
        crit <= 1'b0;
        spin <= 1'b0;
        $display("test override done");
        finish_test();
    end
endmodule // testbench

// *** hdl/fecs_top.sv ***
// enhanced fan configuration register with duty-cycle smoothing ramp
//
// Summary of operation
// R01 - bit 7 of the enhanced config register always reads zero
// R02 - filter LSB enable clear forces remote low byte bits 4:3 to zero
// R03 - enable set with filter on passes the 1/16 and 1/32 bits through
// R04 - resolution extension bit selects 7-bit 1C or 8-bit 0.5C LUT temperatures
// R05 - at 22.5kHz fine select picks 0.39% steps, else 6.25%; ignored elsewhere
// R06 - format bit selects signed or unsigned high and critical setpoints
// R07 - ramp rate field picks 0.023, 0.046, 0.091 or 0.182 s per step
// R08 - ramp rate and ramp enable writes only land while programming enabled
// R09 - ramp enable clear applies duty at once, set ramps at selected interval
// R10 - spin-up and critical override bypass smoothing; only LUT changes ramp
// R11 - smoothing only works while the PWM frequency is 22.5kHz
// R12 - smoothing field and PWM value are read-only unless programming enabled
// R13 - each ramp interval moves duty one increment toward target, then stops
`timescale 1ns/1ps
`include "fecs_regs.svh"

module fecs_top #(
    parameter int RAMP0_CYCLES = `FECS_RAMP_T0_US * `FECS_CLK_MHZ,
    parameter int RAMP1_CYCLES = `FECS_RAMP_T1_US * `FECS_CLK_MHZ,
    parameter int RAMP2_CYCLES = `FECS_RAMP_T2_US * `FECS_CLK_MHZ,
    parameter int RAMP3_CYCLES = `FECS_RAMP_T3_US * `FECS_CLK_MHZ
) (
    input  wire logic        CORE_CLK_IN,
    input  wire logic        RST_B_IN,
    input  wire logic        CLK_EN_IN,
    input  wire logic [9:0]  AVS_ADDRESS_IN,
    input  wire logic        AVS_READ_IN,
    input  wire logic        AVS_WRITE_IN,
    input  wire logic [31:0] AVS_WRITEDATA_IN,
    input  wire logic [3:0]  AVS_BYTEENABLE_IN,
    output logic      [31:0] AVS_READDATA_OUT,
    output logic             AVS_WAITREQUEST_OUT,
    input  wire logic        FREQ_22K5_IN,
    input  wire logic        SPINUP_IN,
    input  wire logic [7:0]  SPINUP_DUTY_IN,
    input  wire logic        CRIT_TEMP_EVENT_IN,
    input  wire logic [7:0]  CRIT_DUTY_IN,
    input  wire logic [7:0]  LUT_DUTY_IN,
    input  wire logic        FILTER_ON_IN,
    input  wire logic [7:0]  REMOTE_LSB_RAW_IN,
    output logic      [7:0]  REMOTE_LSB_OUT,
    output logic      [7:0]  DUTY_OUT,
    output logic             FINE_DUTY_SELECT_OUT,
    output logic             LUT_RESOLUTION_EXT_OUT,
    output logic             SETPOINT_UNSIGNED_FORMAT_OUT,
    output logic             PWM_PROGRAM_ENABLE_OUT,
    output logic             RAMP_ACTIVE_OUT
);
    import fecs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////

    fecs_state_t st_reg;
    fecs_state_t st_next;

    logic [7:0]              word_idx;
    logic                    bus_req;
    logic                    wr_take;
    logic                    fine_mode;
    logic [7:0]              target;
    logic                    smooth;
    logic [`FECS_CNT_W-1:0]  interval;

    // interval length in cycles for a rate code
    function automatic logic [`FECS_CNT_W-1:0] ramp_cycles(input logic [1:0] rate);
        logic [`FECS_CNT_W-1:0] c;
        c = `FECS_CNT_W'(RAMP0_CYCLES);
        case (rate)
            2'h0:    c = `FECS_CNT_W'(RAMP0_CYCLES);
            2'h1:    c = `FECS_CNT_W'(RAMP1_CYCLES);
            2'h2:    c = `FECS_CNT_W'(RAMP2_CYCLES);
            2'h3:    c = `FECS_CNT_W'(RAMP3_CYCLES);
            default: c = `FECS_CNT_W'(RAMP0_CYCLES);
        endcase
        return c;
    endfunction

    // snap a duty value to the active resolution
    function automatic logic [7:0] quantize(input logic [7:0] d, input logic fine);
        logic [7:0] q;
        q = fine ? d : (d & `FECS_COARSE_MASK); // R05
        return q;
    endfunction

    // one increment toward the goal; snaps when closer than one step
    function automatic logic [7:0] step_toward(input logic [7:0] cur,
                                               input logic [7:0] goal,
                                               input logic       fine);
        logic [7:0] stp;
        logic [7:0] r;
        stp = fine ? `FECS_FINE_STEP : `FECS_COARSE_STEP;
        r   = goal;
        if (goal > cur) begin
            if (8'(goal - cur) > stp) begin
                r = 8'(cur + stp);
            end
        end else begin
            if (8'(cur - goal) > stp) begin
                r = 8'(cur - stp);
            end
        end
        return r;
    endfunction

    // register read mux
    function automatic logic [31:0] read_word(input logic [7:0] idx,
                                              input fecs_state_t s);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (idx)
            `FECS_IDX_ENH: begin
                v[6:0] = s.enhanced_config[6:0]; // R01
            end
            `FECS_IDX_FANCFG: begin
                v[`FECS_BIT_PROG] = s.prog_en;
            end
            `FECS_IDX_PWMVAL: begin
                v[7:0] = s.duty;
            end
            default: begin
                v = 32'h0000_0000;
            end
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////

    assign word_idx  = AVS_ADDRESS_IN[9:2];
    assign bus_req   = AVS_READ_IN | AVS_WRITE_IN;
    // writes land on the edge where waitrequest is seen low
    assign wr_take   = AVS_WRITE_IN & ~st_reg.waitreq & AVS_BYTEENABLE_IN[0];
    // fine select has no effect unless the PWM runs at 22.5kHz
    assign fine_mode = FREQ_22K5_IN & st_reg.enhanced_config[`FECS_BIT_FINE]; // R05
    assign interval  = ramp_cycles(st_reg.enhanced_config[`FECS_BIT_RATE_HI:`FECS_BIT_RATE_LO]); // R07

    // duty source priority: critical override, spin-up, manual value, lookup table
    always_comb begin
        target = LUT_DUTY_IN;
        smooth = 1'b0;
        if (CRIT_TEMP_EVENT_IN) begin
            target = CRIT_DUTY_IN; // R10
        end else if (SPINUP_IN) begin
            target = SPINUP_DUTY_IN; // R10
        end else if (st_reg.prog_en) begin
            target = st_reg.pwm_val;
        end else begin
            target = LUT_DUTY_IN;
            smooth = st_reg.enhanced_config[`FECS_BIT_RAMP_EN] & FREQ_22K5_IN; // R09 R11
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        st_next = st_reg;

        // bus handshake: one wait cycle, then a single answer cycle
        if (bus_req & st_reg.waitreq) begin
            st_next.waitreq = 1'b0;
            st_next.rdata   = read_word(word_idx, st_reg);
        end else begin
            st_next.waitreq = 1'b1;
        end

        if (wr_take) begin
            case (word_idx)
                `FECS_IDX_ENH: begin
                    st_next.enhanced_config[`FECS_BIT_FILT] = AVS_WRITEDATA_IN[`FECS_BIT_FILT];
                    st_next.enhanced_config[`FECS_BIT_LUT_RESOLUTION_EXT] = AVS_WRITEDATA_IN[`FECS_BIT_LUT_RESOLUTION_EXT]; // R04
                    st_next.enhanced_config[`FECS_BIT_FINE] = AVS_WRITEDATA_IN[`FECS_BIT_FINE];
                    st_next.enhanced_config[`FECS_BIT_USF]  = AVS_WRITEDATA_IN[`FECS_BIT_USF]; // R06
                    if (st_reg.prog_en) begin
                        st_next.enhanced_config[2:0] = AVS_WRITEDATA_IN[2:0]; // R08 R12
                    end
                end
                `FECS_IDX_FANCFG: begin
                    st_next.prog_en = AVS_WRITEDATA_IN[`FECS_BIT_PROG];
                end
                `FECS_IDX_PWMVAL: begin
                    if (st_reg.prog_en) begin
                        st_next.pwm_val = AVS_WRITEDATA_IN[7:0]; // R12
                    end
                end
                default: begin
                    st_next.pwm_val = st_reg.pwm_val;
                end
            endcase
        end
        st_next.enhanced_config[`FECS_BIT_RSVD] = 1'b0; // R01

        // extra filter bits only when enabled and the filter is running
        if (st_reg.enhanced_config[`FECS_BIT_FILT] & FILTER_ON_IN) begin
            st_next.rem_lsb = REMOTE_LSB_RAW_IN; // R03
        end else begin
            st_next.rem_lsb = REMOTE_LSB_RAW_IN & `FECS_LSB_MASK; // R02
        end

        // smoothing ramp; anything but a smoothed LUT change goes straight through
        if (!smooth) begin
            st_next.duty = quantize(target, fine_mode); // R09 R10
            st_next.cnt  = '0;
            st_next.ramp = FECS_HOLD;
        end else begin
            case (st_reg.ramp)
                FECS_HOLD: begin
                    st_next.cnt = '0;
                    if (st_reg.duty != quantize(target, fine_mode)) begin
                        st_next.ramp = FECS_RAMP;
                    end
                end
                FECS_RAMP: begin
                    if (st_reg.duty == quantize(target, fine_mode)) begin
                        st_next.ramp = FECS_HOLD; // R13
                        st_next.cnt  = '0;
                    end else if (st_reg.cnt >= `FECS_CNT_W'(interval - 1'b1)) begin
                        st_next.cnt  = '0;
                        st_next.duty = step_toward(st_reg.duty,
                                                   quantize(target, fine_mode),
                                                   fine_mode); // R13
                    end else begin
                        st_next.cnt = `FECS_CNT_W'(st_reg.cnt + 1'b1); // R07
                    end
                end
                default: begin
                    st_next.ramp = FECS_HOLD;
                    st_next.cnt  = '0;
                end
            endcase
        end

        // a low enable freezes everything, bus handshake included
        if (!CLK_EN_IN) begin
            st_next = st_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            st_reg.enhanced_config     <= `FECS_ENH_RST;
            st_reg.prog_en <= `FECS_PROG_RST;
            st_reg.pwm_val <= `FECS_PWMVAL_RST;
            st_reg.duty    <= 8'h00;
            st_reg.cnt     <= '0;
            st_reg.ramp    <= FECS_HOLD;
            st_reg.waitreq <= 1'b1;
            st_reg.rdata   <= 32'h0000_0000;
            st_reg.rem_lsb <= 8'h00;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    assign AVS_READDATA_OUT             = st_reg.rdata;
    assign AVS_WAITREQUEST_OUT          = st_reg.waitreq;
    assign REMOTE_LSB_OUT               = st_reg.rem_lsb;
    assign DUTY_OUT                     = st_reg.duty;
    assign FINE_DUTY_SELECT_OUT         = st_reg.enhanced_config[`FECS_BIT_FINE];
    // consumers read LUT temperatures and setpoints in the format these select
    assign LUT_RESOLUTION_EXT_OUT       = st_reg.enhanced_config[`FECS_BIT_LUT_RESOLUTION_EXT]; // R04
    assign SETPOINT_UNSIGNED_FORMAT_OUT = st_reg.enhanced_config[`FECS_BIT_USF]; // R06
    assign PWM_PROGRAM_ENABLE_OUT       = st_reg.prog_en;
    assign RAMP_ACTIVE_OUT              = (st_reg.ramp == FECS_RAMP);

endmodule // fecs_top

// *** inc/fecs_pkg.sv ***
// types shared by the fan config and smoothing block
`include "fecs_regs.svh"

package fecs_pkg;

    typedef enum logic {
        FECS_HOLD,
        FECS_RAMP
    } fecs_ramp_t;

    typedef struct packed {
        logic [7:0]              enhanced_config;
        logic                    prog_en;
        logic [7:0]              pwm_val;
        logic [7:0]              duty;
        logic [`FECS_CNT_W-1:0]  cnt;
        fecs_ramp_t              ramp;
        logic                    waitreq;
        logic [31:0]             rdata;
        logic [7:0]              rem_lsb;
    } fecs_state_t;

endpackage

// *** inc/fecs_regs.svh ***
// register indices, field positions, reset values and timing figures of the fan config block
`ifndef FECS_REGS_SVH
`define FECS_REGS_SVH

`define FECS_IDX_ENH        8'h45
`define FECS_IDX_FANCFG     8'h4A
`define FECS_IDX_PWMVAL     8'h4C

`define FECS_ENH_RST        8'h00
`define FECS_PROG_RST       1'b1
`define FECS_PWMVAL_RST     8'h00

`define FECS_BIT_RSVD       7
`define FECS_BIT_FILT       6
`define FECS_BIT_LUT_RESOLUTION_EXT       5
`define FECS_BIT_FINE       4
`define FECS_BIT_USF        3
`define FECS_BIT_RATE_HI    2
`define FECS_BIT_RATE_LO    1
`define FECS_BIT_RAMP_EN    0
`define FECS_BIT_PROG       5

`define FECS_LSB_MASK       8'hE7
`define FECS_COARSE_MASK    8'hF0
`define FECS_COARSE_STEP    8'h10
`define FECS_FINE_STEP      8'h01

`define FECS_CLK_MHZ        100
`define FECS_RAMP_T0_US     23000
`define FECS_RAMP_T1_US     46000
`define FECS_RAMP_T2_US     91000
`define FECS_RAMP_T3_US     182000
`define FECS_CNT_W          25

`endif
